// ### verilog/rcf_defs.svh
// Constants for the reset cause flag logic
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH
// Register addresses
`define RCF_ADDR_STATUS 8'h03
`define RCF_ADDR_CAUSE 8'h8E
`define RCF_ADDR_EVT_STATUS 8'h90
`define RCF_ADDR_EVT_MASK 8'h91
// Bit positions in the core status register
`define RCF_BIT_TIMEOUT 4
`define RCF_BIT_POWER_DOWN 3
`define RCF_BANK_LSB 5
`define RCF_ARITH_MSB 2
// Bit positions in the power reset cause register
`define RCF_BIT_POWER_ON 1
`define RCF_BIT_BROWNOUT 0
`define RCF_CAUSE_W 2
// Values loaded on the various causes
`define RCF_STATUS_RESET 8'h18
`define RCF_CAUSE_RESET 2'h0
`define RCF_CAUSE_AFTER_BROWNOUT 2'h2
`define RCF_UPPER_AFTER_BROWNOUT 5'h03
`define RCF_UPPER_AFTER_CLEAR_SLEEP 5'h02
`define RCF_BANK_CLEARED 3'h0
// Program counter
`define RCF_PC_W 13
`define RCF_PC_START 13'h0000
`define RCF_INT_VECTOR 13'h0004
`define RCF_PC_STEP 13'h0001
// Event indices in the interrupt status register
`define RCF_EV_W 7
`define RCF_EV_POWER_ON 0
`define RCF_EV_BROWNOUT 1
`define RCF_EV_WDOG_RESET 2
`define RCF_EV_WDOG_WAKE 3
`define RCF_EV_CLEAR_RUN 4
`define RCF_EV_CLEAR_SLEEP 5
`define RCF_EV_INT_WAKE 6
`endif

// ### verilog/rcf_pkg.sv
// Types for the reset cause flag logic
`default_nettype none
`include "rcf_defs.svh"
package rcf_pkg;
  // Vector fetch sequencing after an interrupt wake-up
  typedef enum logic [0:0] {
    RCF_IDLE,
    RCF_VEC_WAIT
  } rcf_state_type;

  // All state of the top module
  typedef struct packed {
    rcf_state_type state;
    logic [7:0] status;
    logic [`RCF_CAUSE_W-1:0] cause;
    logic pc_load;
    logic [`RCF_PC_W-1:0] pc_value;
    logic [7:0] rdata;
  } rcf_core_type;

  // All state of the event unit
  typedef struct packed {
    logic [`RCF_EV_W-1:0] status;
    logic [`RCF_EV_W-1:0] mask;
    logic irq;
  } rcf_evt_type;
endpackage
`default_nettype wire

// ### verilog/rcf_evt_if.sv
// Link between the flag logic and its event unit
`timescale 1ns/1ps
`default_nettype none
`include "rcf_defs.svh"
interface rcf_evt_if;
  logic [`RCF_EV_W-1:0] event_set; // One-cycle cause pulses
  logic wr_status; // Write-one-to-clear strobe
  logic wr_mask; // Mask write strobe
  logic [`RCF_EV_W-1:0] wdata; // Write data
  logic [`RCF_EV_W-1:0] status; // Sticky bits
  logic [`RCF_EV_W-1:0] mask; // Enables
  logic irq; // Registered interrupt level
  modport core (output event_set, wr_status, wr_mask, wdata, input status, mask, irq);
  modport unit (input event_set, wr_status, wr_mask, wdata, output status, mask, irq);
endinterface
`default_nettype wire

// ### verilog/rcf_event_unit.sv
// Sticky event status, mask and interrupt level
`timescale 1ns/1ps
`default_nettype none
`include "rcf_defs.svh"
module rcf_event_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link to the flag logic
  rcf_evt_if.unit evt
);
  rcf_pkg::rcf_evt_type st_reg; // Registered state
  rcf_pkg::rcf_evt_type st_next; // Next state

  // Set beats clear so a cause arriving during a clear is kept
  always_comb begin
    st_next = st_reg;
    if (evt.wr_status) begin
      st_next.status = st_reg.status & ~evt.wdata;
    end
    st_next.status = st_next.status | evt.event_set;
    if (evt.wr_mask) begin
      st_next.mask = evt.wdata;
    end
    st_next.irq = |(st_next.status & st_next.mask);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign evt.status = st_reg.status;
  assign evt.mask = st_reg.mask;
  assign evt.irq = st_reg.irq;

  // Checks
  property p_set_wins;
    @(posedge clk_i) disable iff (reset_i)
    (evt.event_set[`RCF_EV_POWER_ON] && evt.wr_status) |=> evt.status[`RCF_EV_POWER_ON];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under clear");
endmodule
`default_nettype wire

// ### verilog/rcf_flags.sv
// Reset and wake-up cause flags, start address and register port
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rcf_defs.svh"
// Summary of operation
// [R1] Four cause flags, fixed pattern per cause
// [R2] Power-on: start zero, status 0001 1xxx
// [R3] Clear running: zero banks, keep rest
// [R4] Clear asleep: banks zero, timeout set, powerdown cleared
// [R5] Interrupt wake: next PC, timeout set, powerdown cleared
// [R6] Interrupts enabled: run next, then vector
// [R7] Resets running: upper three cleared, flags per cause
// [R8] Unused cause bits ignore writes, read zero
// [R9] Firmware sets power-on flag after power-on
// [R10] Brown-out flag meaningless when detector disabled
// [R11] Flag positions: status 4/3, cause 1/0
module rcf_flags (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Reset and wake-up causes, one-cycle pulses
  input wire logic power_on_event_i,
  input wire logic brownout_event_i,
  input wire logic watchdog_event_i,
  input wire logic external_clear_pin_event_i,
  input wire logic interrupt_wake_i,
  // Core context
  input wire logic sleeping_i,
  input wire logic brownout_detector_enable_i,
  input wire logic global_interrupt_enable_i,
  input wire logic [`RCF_PC_W-1:0] pc_i,
  input wire logic instr_done_i,
  // Program counter load
  output logic pc_load_o,
  output logic [`RCF_PC_W-1:0] pc_value_o,
  // Flag registers as seen by the core
  output logic [7:0] core_status_flags_o,
  output logic [`RCF_CAUSE_W-1:0] power_reset_cause_o,
  output logic irq_o,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);
  rcf_pkg::rcf_core_type st_reg; // Registered state
  rcf_pkg::rcf_core_type st_next; // Next state
  logic [`RCF_EV_W-1:0] taken; // Cause acted on this cycle, one-hot
  logic [`RCF_PC_W-1:0] pc_plus; // Address of the next instruction

  rcf_evt_if evt (); // Link to the event unit

  // Sticky cause bits and interrupt level
  rcf_event_unit u_events (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .evt(evt)
  );

  assign pc_plus = pc_i + `RCF_PC_STEP;

  // Cause selection by priority, a power cycle outranks everything
  always_comb begin
    taken = '0;
    if (power_on_event_i) begin
      taken[`RCF_EV_POWER_ON] = 1'b1;
    end else if (brownout_event_i && brownout_detector_enable_i) begin
      // A disabled detector cannot claim a cause
      taken[`RCF_EV_BROWNOUT] = 1'b1; // R10
    end else if (watchdog_event_i && !sleeping_i) begin
      taken[`RCF_EV_WDOG_RESET] = 1'b1;
    end else if (watchdog_event_i) begin
      taken[`RCF_EV_WDOG_WAKE] = 1'b1;
    end else if (external_clear_pin_event_i && sleeping_i) begin
      taken[`RCF_EV_CLEAR_SLEEP] = 1'b1;
    end else if (external_clear_pin_event_i) begin
      taken[`RCF_EV_CLEAR_RUN] = 1'b1;
    end else if (interrupt_wake_i) begin
      taken[`RCF_EV_INT_WAKE] = 1'b1;
    end
  end

  // Next state: software writes first, then causes override them
  always_comb begin
    st_next = st_reg;
    st_next.pc_load = 1'b0;
    st_next.rdata = 8'h00;
    // Software writes; the timeout and power-down flags are read only
    if (wr_i && addr_i == `RCF_ADDR_STATUS) begin
      st_next.status = wdata_i;
      st_next.status[`RCF_BIT_TIMEOUT] = st_reg.status[`RCF_BIT_TIMEOUT];
      st_next.status[`RCF_BIT_POWER_DOWN] = st_reg.status[`RCF_BIT_POWER_DOWN];
    end
    if (wr_i && addr_i == `RCF_ADDR_CAUSE) begin
      // Only the two flag bits are stored, upper bits dropped
      st_next.cause = wdata_i[`RCF_CAUSE_W-1:0]; // R8 R9
    end
    // Cause handling, each with its own flag pattern
    if (taken[`RCF_EV_POWER_ON]) begin
      st_next.status = `RCF_STATUS_RESET; // R2 R1
      st_next.cause[`RCF_BIT_POWER_ON] = 1'b0; // R2 R11
      st_next.pc_load = 1'b1;
      st_next.pc_value = `RCF_PC_START; // R2
      st_next.state = rcf_pkg::RCF_IDLE;
    end else if (taken[`RCF_EV_BROWNOUT]) begin
      // Upper bits 0001 1, arithmetic bits kept
      st_next.status[7:`RCF_BIT_POWER_DOWN] = `RCF_UPPER_AFTER_BROWNOUT; // R7 R1
      st_next.cause = `RCF_CAUSE_AFTER_BROWNOUT; // R1 R11
      st_next.pc_load = 1'b1;
      st_next.pc_value = `RCF_PC_START;
      st_next.state = rcf_pkg::RCF_IDLE;
    end else if (taken[`RCF_EV_WDOG_RESET]) begin
      // Banks and timeout cleared, power-down kept
      st_next.status[7:`RCF_BANK_LSB] = `RCF_BANK_CLEARED; // R7
      st_next.status[`RCF_BIT_TIMEOUT] = 1'b0; // R7 R1
      st_next.pc_load = 1'b1;
      st_next.pc_value = `RCF_PC_START;
      st_next.state = rcf_pkg::RCF_IDLE;
    end else if (taken[`RCF_EV_WDOG_WAKE]) begin
      // Resumption, not a reset: banks untouched
      st_next.status[`RCF_BIT_TIMEOUT] = 1'b0; // R1
      st_next.status[`RCF_BIT_POWER_DOWN] = 1'b0; // R1
      st_next.pc_load = 1'b1;
      st_next.pc_value = pc_plus;
      st_next.state = rcf_pkg::RCF_IDLE;
    end else if (taken[`RCF_EV_CLEAR_SLEEP]) begin
      st_next.status[7:`RCF_BIT_POWER_DOWN] = `RCF_UPPER_AFTER_CLEAR_SLEEP; // R4 R1
      st_next.pc_load = 1'b1;
      st_next.pc_value = `RCF_PC_START; // R4
      st_next.state = rcf_pkg::RCF_IDLE;
    end else if (taken[`RCF_EV_CLEAR_RUN]) begin
      // Only the bank bits move, cause flags untouched
      st_next.status[7:`RCF_BANK_LSB] = `RCF_BANK_CLEARED; // R3 R7
      st_next.pc_load = 1'b1;
      st_next.pc_value = `RCF_PC_START; // R3
      st_next.state = rcf_pkg::RCF_IDLE;
    end else if (taken[`RCF_EV_INT_WAKE]) begin
      st_next.status[`RCF_BIT_TIMEOUT] = 1'b1; // R5 R1
      st_next.status[`RCF_BIT_POWER_DOWN] = 1'b0; // R5 R1
      st_next.pc_load = 1'b1;
      st_next.pc_value = pc_plus; // R5
      // With interrupts on, the vector follows the next instruction
      if (global_interrupt_enable_i) begin
        st_next.state = rcf_pkg::RCF_VEC_WAIT; // R6
      end else begin
        st_next.state = rcf_pkg::RCF_IDLE;
      end
    end else begin
      // No cause: finish a pending vector fetch
      case (st_reg.state)
        rcf_pkg::RCF_IDLE: begin
          st_next.state = rcf_pkg::RCF_IDLE;
        end
        rcf_pkg::RCF_VEC_WAIT: begin
          if (instr_done_i) begin
            st_next.pc_load = 1'b1;
            st_next.pc_value = `RCF_INT_VECTOR; // R6
            st_next.state = rcf_pkg::RCF_IDLE;
          end
        end
        default: begin
          st_next.state = rcf_pkg::RCF_IDLE;
        end
      endcase
    end
    // Read data shows the values before this cycle's update
    if (rd_i) begin
      case (addr_i)
        `RCF_ADDR_STATUS: begin
          st_next.rdata = st_reg.status;
        end
        `RCF_ADDR_CAUSE: begin
          // Unused positions read as zero
          st_next.rdata = {6'h00, st_reg.cause}; // R8
        end
        `RCF_ADDR_EVT_STATUS: begin
          st_next.rdata = {1'b0, evt.status};
        end
        `RCF_ADDR_EVT_MASK: begin
          st_next.rdata = {1'b0, evt.mask};
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register, synchronous reset to a power-on image
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg.state <= rcf_pkg::RCF_IDLE;
      st_reg.status <= `RCF_STATUS_RESET;
      st_reg.cause <= `RCF_CAUSE_RESET;
      st_reg.pc_load <= 1'b0;
      st_reg.pc_value <= `RCF_PC_START;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // Event unit drive
  assign evt.event_set = taken;
  assign evt.wr_status = wr_i && addr_i == `RCF_ADDR_EVT_STATUS;
  assign evt.wr_mask = wr_i && addr_i == `RCF_ADDR_EVT_MASK;
  assign evt.wdata = wdata_i[`RCF_EV_W-1:0];

  // Outputs
  assign pc_load_o = st_reg.pc_load;
  assign pc_value_o = st_reg.pc_value;
  assign core_status_flags_o = st_reg.status;
  assign power_reset_cause_o = st_reg.cause;
  assign irq_o = evt.irq;
  assign rdata_o = st_reg.rdata;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Cause images, one property per pattern
  property p_power_on;
    taken[`RCF_EV_POWER_ON] |=> core_status_flags_o == `RCF_STATUS_RESET
      && !power_reset_cause_o[`RCF_BIT_POWER_ON] && pc_load_o && pc_value_o == `RCF_PC_START;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on image wrong"); // R2

  property p_brownout;
    taken[`RCF_EV_BROWNOUT] |=> power_reset_cause_o == `RCF_CAUSE_AFTER_BROWNOUT
      && core_status_flags_o[7:3] == `RCF_UPPER_AFTER_BROWNOUT
      && core_status_flags_o[2:0] == $past(core_status_flags_o[2:0]);
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out image wrong"); // R11

  property p_bod_off;
    (brownout_event_i && !brownout_detector_enable_i && !power_on_event_i && !wr_i)
      |=> power_reset_cause_o == $past(power_reset_cause_o);
  endproperty
  a_bod_off: assert property (p_bod_off) else $error("disabled detector moved flag"); // R10

  property p_wdog_reset;
    taken[`RCF_EV_WDOG_RESET] |=> core_status_flags_o[7:4] == 4'h0
      && core_status_flags_o[3:0] == $past(core_status_flags_o[3:0]) && pc_load_o;
  endproperty
  a_wdog_reset: assert property (p_wdog_reset) else $error("watchdog reset image wrong"); // R7

  property p_wdog_wake;
    taken[`RCF_EV_WDOG_WAKE] |=> core_status_flags_o[4:3] == 2'h0
      && pc_value_o == $past(pc_i) + `RCF_PC_STEP;
  endproperty
  a_wdog_wake: assert property (p_wdog_wake) else $error("watchdog wake image wrong"); // R1

  property p_clear_run;
    taken[`RCF_EV_CLEAR_RUN] |=> core_status_flags_o[7:5] == 3'h0
      && core_status_flags_o[4:0] == $past(core_status_flags_o[4:0])
      && power_reset_cause_o == $past(power_reset_cause_o);
  endproperty
  a_clear_run: assert property (p_clear_run) else $error("clear while running wrong"); // R3

  property p_clear_sleep;
    taken[`RCF_EV_CLEAR_SLEEP] |=> core_status_flags_o[7:3] == `RCF_UPPER_AFTER_CLEAR_SLEEP
      && core_status_flags_o[2:0] == $past(core_status_flags_o[2:0])
      && pc_value_o == `RCF_PC_START;
  endproperty
  a_clear_sleep: assert property (p_clear_sleep) else $error("clear in sleep wrong"); // R4

  property p_int_wake;
    taken[`RCF_EV_INT_WAKE] |=> core_status_flags_o[4:3] == 2'h2
      && core_status_flags_o[7:5] == $past(core_status_flags_o[7:5])
      && pc_value_o == $past(pc_i) + `RCF_PC_STEP;
  endproperty
  a_int_wake: assert property (p_int_wake) else $error("interrupt wake image wrong"); // R5

  // Vector follows the first finished instruction after the wake
  property p_vector;
    (st_reg.state == rcf_pkg::RCF_VEC_WAIT && instr_done_i && taken == '0)
      |=> pc_load_o && pc_value_o == `RCF_INT_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("vector not loaded"); // R6

  property p_cause_read;
    (rd_i && addr_i == `RCF_ADDR_CAUSE) |=> rdata_o[7:2] == 6'h00
      && rdata_o[1:0] == $past(power_reset_cause_o);
  endproperty
  a_cause_read: assert property (p_cause_read) else $error("cause read wrong"); // R8

  // Status reads return the flags as they stood at the read
  property p_status_read;
    (rd_i && addr_i == `RCF_ADDR_STATUS) |=> rdata_o == $past(core_status_flags_o);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // R11

  // Holes in the map read as zero
  property p_unmapped_read;
    (rd_i && !(addr_i inside {`RCF_ADDR_STATUS, `RCF_ADDR_CAUSE, `RCF_ADDR_EVT_STATUS,
      `RCF_ADDR_EVT_MASK})) |=> rdata_o == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // R8

  // Read port idles at zero so stale flags are never taken for fresh ones
  property p_rdata_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // R8

  // Software cannot forge the timeout or power-down flags
  property p_flags_read_only;
    (wr_i && addr_i == `RCF_ADDR_STATUS && taken == '0)
      |=> core_status_flags_o[4:3] == $past(core_status_flags_o[4:3]);
  endproperty
  a_flags_read_only: assert property (p_flags_read_only) else $error("flag written"); // R1

  // Firmware writes reach the two cause flags only
  property p_cause_write;
    (wr_i && addr_i == `RCF_ADDR_CAUSE && taken == '0)
      |=> power_reset_cause_o == $past(wdata_i[`RCF_CAUSE_W-1:0]);
  endproperty
  a_cause_write: assert property (p_cause_write) else $error("cause write lost"); // R8

  // Without a cause or a pending vector the core is never redirected
  property p_no_cause_no_load;
    (taken == '0 && st_reg.state == rcf_pkg::RCF_IDLE) |=> !pc_load_o;
  endproperty
  a_no_cause_no_load: assert property (p_no_cause_no_load) else $error("stray load"); // R1

  // An enabled wake arms the vector fetch
  property p_vec_enter;
    (taken[`RCF_EV_INT_WAKE] && global_interrupt_enable_i)
      |=> st_reg.state == rcf_pkg::RCF_VEC_WAIT && pc_load_o;
  endproperty
  a_vec_enter: assert property (p_vec_enter) else $error("vector fetch not armed"); // R6

  // No vector until the next instruction has finished
  property p_vec_hold;
    (st_reg.state == rcf_pkg::RCF_VEC_WAIT && !instr_done_i && taken == '0) |=> !pc_load_o;
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector loaded too early"); // R6

  // Main scenarios worth seeing
  c_power_on: cover property (taken[`RCF_EV_POWER_ON] ##1 pc_load_o);
  c_vec_wait: cover property (st_reg.state == rcf_pkg::RCF_VEC_WAIT && instr_done_i);
  c_vector: cover property (pc_load_o && pc_value_o == `RCF_INT_VECTOR);
  c_brownout_irq: cover property (taken[`RCF_EV_BROWNOUT] ##2 irq_o);
endmodule
`default_nettype wire

// ### sim/rcf_core_model.sv
// Behavioural model of the processor core beside the flag logic
`timescale 1ns/1ps
`default_nettype none
`include "rcf_defs.svh"
module rcf_core_model #(
  parameter int GAP = 3 // Cycles per instruction, larger means a slower core
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Program counter load from the flag logic
  input wire logic pc_load_i,
  input wire logic [`RCF_PC_W-1:0] pc_value_i,
  // Execution control from the bench
  input wire logic run_i,
  // Core state towards the flag logic
  output logic [`RCF_PC_W-1:0] pc_o,
  output logic instr_done_o
);
  int cnt; // Cycles into the current instruction
  // Load wins over stepping, so a vector fetch is never lost
  always_ff @(posedge clk_i) begin
    instr_done_o <= 1'b0;
    if (reset_i) begin
      pc_o <= '0;
      cnt <= 0;
    end else if (pc_load_i) begin
      pc_o <= pc_value_i;
      cnt <= 0;
    end else if (run_i) begin
      // Running core finishes one instruction every GAP cycles
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      if (cnt == GAP - 1) begin
        instr_done_o <= 1'b1;
        pc_o <= pc_o + `RCF_PC_STEP;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/reset_cause_flag_logic_bench.sv
// Self-checking bench for the reset cause flag logic
`timescale 1ns/1ps
`default_nettype none
`include "rcf_defs.svh"
module reset_cause_flag_logic_bench;
  // Row: cause pulses, context, expected flags
  typedef struct packed {
    logic [4:0] src;
    logic slp;
    logic [2:0] evb;
    logic [4:0] up;
    logic [1:0] cs;
    logic pcnext;
  } rcf_row_type;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [4:0] cause_q = '0; // Pulses: power-on, brown-out, watchdog, clear, wake
  logic sleeping = 1'b0;
  logic bod_en = 1'b1;
  logic global_interrupt_enable = 1'b0;
  logic run = 1'b0;
  logic [7:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [`RCF_PC_W-1:0] pc, pc_value, pcs;
  logic instr_done, pc_load, irq;
  logic [7:0] status, rdata, got;
  logic [1:0] cause;
  int mismatches = 0;
  int compares = 0;
  // Lower status bits stay 101 from the status write before each row, power-on clears them
  rcf_row_type rows [7] = '{
    '{5'h01, 1'b0, 3'd0, 5'b00011, 2'b01, 1'b0},
    '{5'h02, 1'b0, 3'd1, 5'b00011, 2'b10, 1'b0},
    '{5'h04, 1'b0, 3'd2, 5'b00001, 2'b11, 1'b0},
    '{5'h04, 1'b1, 3'd3, 5'b11100, 2'b11, 1'b1},
    '{5'h08, 1'b0, 3'd4, 5'b00000, 2'b11, 1'b0},
    '{5'h08, 1'b1, 3'd5, 5'b00010, 2'b11, 1'b0},
    '{5'h10, 1'b1, 3'd6, 5'b11110, 2'b11, 1'b1}};
  rcf_flags u_dut (
    .clk_i(clk_i), .reset_i(reset_i),
    .power_on_event_i(cause_q[0]), .brownout_event_i(cause_q[1]),
    .watchdog_event_i(cause_q[2]), .external_clear_pin_event_i(cause_q[3]),
    .interrupt_wake_i(cause_q[4]), .sleeping_i(sleeping),
    .brownout_detector_enable_i(bod_en), .global_interrupt_enable_i(global_interrupt_enable),
    .pc_i(pc), .instr_done_i(instr_done), .pc_load_o(pc_load),
    .pc_value_o(pc_value), .core_status_flags_o(status),
    .power_reset_cause_o(cause), .irq_o(irq), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  rcf_core_model #(.GAP(3)) u_core (
    .clk_i(clk_i), .reset_i(reset_i), .pc_load_i(pc_load),
    .pc_value_i(pc_value), .run_i(run), .pc_o(pc), .instr_done_o(instr_done));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // One compare, reported at once
  task automatic chk(input logic [12:0] g, input logic [12:0] e, input string m);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  // Single-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  // Single-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  // Cause pulse with its context, returns 1 ns after it lands for the caller to check
  task automatic pulse(input logic [4:0] s, input logic slp, input logic g);
    @(posedge clk_i);
    sleeping <= slp;
    global_interrupt_enable <= g;
    cause_q <= s;
    pcs = pc;
    @(posedge clk_i);
    cause_q <= '0;
    #1;
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected 150 or so cycles
  initial begin
    #(25 * 5000);
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk(status, 8'h18, "reset status");
    chk(cause, 2'h0, "reset cause");
    wr_reg(8'h8E, 8'hFF);
    rd_reg(8'h8E);
    chk(got, 8'h03, "cause unused bits");
    @(posedge clk_i);
    #1;
    chk(rdata, 8'h00, "read data one cycle");
    rd_reg(8'h55);
    chk(got, 8'h00, "unmapped read");
    wr_reg(8'h91, 8'h7F);
    // Table of causes, each from a known register state
    foreach (rows[i]) begin
      wr_reg(8'h03, 8'hE5);
      wr_reg(8'h8E, 8'h03);
      pulse(rows[i].src, rows[i].slp, 1'b0);
      chk(pc_load, 1'b1, "pc load");
      chk(pc_value, rows[i].pcnext ? pcs + 13'h0001 : 13'h0000, "pc value");
      chk(status, {rows[i].up, rows[i].src[0] ? 3'b000 : 3'b101}, "status pattern");
      chk(cause, rows[i].cs, "cause pattern");
      @(posedge clk_i);
      #1;
      chk(irq, 1'b1, "irq raised");
      chk(pc_load, 1'b0, "pc load one cycle");
      rd_reg(8'h90);
      chk(got, 8'h01 << rows[i].evb, "event bit");
      wr_reg(8'h90, 8'h7F);
      repeat (2) @(posedge clk_i);
      #1;
      chk(irq, 1'b0, "irq cleared");
    end
    // Timeout and power-down bits ignore writes
    rd_reg(8'h03);
    chk(got[4:3], 2'b10, "flags before write");
    wr_reg(8'h03, 8'h00);
    rd_reg(8'h03);
    chk(got, {3'b000, 2'b10, 3'b000}, "status write");
    // Brown-out with detector off leaves the flag alone
    wr_reg(8'h8E, 8'h03);
    bod_en <= 1'b0;
    pulse(5'h02, 1'b0, 1'b0);
    chk(pc_load, 1'b0, "disabled bod load");
    chk(cause, 2'h3, "disabled bod flag");
    bod_en <= 1'b1;
    // Power-on outranks a watchdog in the same cycle
    pulse(5'h05, 1'b0, 1'b0);
    chk(status[7:3], 5'b00011, "priority");
    // Power-on lands in the same cycle as a clear of its event bit
    @(posedge clk_i);
    cause_q <= 5'h01;
    addr <= 8'h90;
    wdata <= 8'h7F;
    wr <= 1'b1;
    @(posedge clk_i);
    cause_q <= '0;
    wr <= 1'b0;
    rd_reg(8'h90);
    chk(got, 8'h01, "event kept under clear");
    // Masked event keeps the interrupt low
    wr_reg(8'h90, 8'h7F);
    wr_reg(8'h91, 8'h00);
    pulse(5'h08, 1'b0, 1'b0);
    repeat (2) @(posedge clk_i);
    #1;
    chk(irq, 1'b0, "masked irq");
    wr_reg(8'h91, 8'h10);
    repeat (2) @(posedge clk_i);
    #1;
    chk(irq, 1'b1, "unmasked irq");
    // Wake with interrupts on: next address, then vector
    pulse(5'h10, 1'b1, 1'b1);
    chk(pc_value, pcs + 13'h0001, "wake next");
    // Let the wake load pass before looking for the vector load
    @(posedge clk_i);
    sleeping <= 1'b0;
    run <= 1'b1;
    #1;
    for (int k = 0; k < 50 && !(pc_load === 1'b1); k++) begin
      @(posedge clk_i);
      #1;
    end
    chk(pc_load, 1'b1, "vector load");
    chk(pc, pcs + 13'h0002, "next instruction ran first");
    chk(pc_value, `RCF_INT_VECTOR, "vector");
    run <= 1'b0;
    // Reset in mid-run
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk(status, 8'h18, "second reset status");
    chk(irq, 1'b0, "second reset irq");
    chk(pc_load, 1'b0, "second reset load");
    rd_reg(8'h8E);
    chk(got, 8'h00, "read after reset");
    give_verdict();
  end
endmodule
`default_nettype wire
